// *** crs_register_set.sv ***
// Function
// - General registers are 32 bits; byte and word writes leave upper bits untouched.
// - Six address registers keep 24 bits, upper 8 read zero; module pointer 16 bits.
// - Current stack pointer is kernel pointer when pick bit 0, user when 1.
// - Push pre-decrements by operand size; pop post-increments by operand size.
// - Descriptor addresses from the module pointer stay within the lowest 64 kbytes.
// - Status low byte writable by anyone; high byte only in supervisor mode.
// - Borrow flag records carry or borrow of add and subtract; fed back as carry in.
// - With trace bit set a trace trap follows every instruction.
// - Compare sets unsigned-under flag if second below first unsigned; float clears it.
// - Compare sets equal flag when operands equal, else clears it.
// - Compare sets less-with-polarity flag on signed second below first.
// - General-condition flag updated by instructions; arithmetic sets it on overflow.
// - In user mode privileged instructions and protected accesses are refused.
// - Every interrupt or trap clears the stack pick bit.
// - Trace pending bit ensures at most one trace trap per instruction.
// - Maskable-accept bit gates maskable interrupts; non-maskable always taken.
// - Blit bit set during external blit drives select low; reset clears it.
// - Acknowledge clears blit, accept, pending, pick, privilege bits; return restores word.
// - Setup register is 8 bits, four implemented, loaded only by setup write op.
// - Vectored-mode bit selects non-vectored at 0, vectored at 1.
// - Float op traps illegal when math unit absent, else dispatched to math unit.
// - Memory is little-endian byte addressed; low word goes at lower address.
`default_nettype none
module crs_register_set (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // General register access
  input wire logic [2:0] gen_rd_sel,
  input wire logic [1:0] gen_rd_size,
  output logic [31:0] gen_rd_data,
  input wire logic gen_wr_en,
  input wire logic [2:0] gen_wr_sel,
  input wire logic [1:0] gen_wr_size,
  input wire logic [31:0] gen_wr_data,
  // Address register access
  input wire logic [2:0] addr_rd_sel,
  output logic [31:0] addr_rd_data,
  input wire logic addr_wr_en,
  input wire logic [2:0] addr_wr_sel,
  input wire logic [31:0] addr_wr_data,
  output logic [31:0] descriptor_addr,
  // Stack operations
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [1:0] stack_size,
  output logic [31:0] stack_addr,
  // Condition flag updates
  input wire logic cmp_en,
  input wire logic cmp_float,
  input wire logic [31:0] cmp_first,
  input wire logic [31:0] cmp_second,
  input wire logic arith_en,
  input wire logic arith_carry,
  input wire logic arith_overflow,
  input wire logic flag_f_wr,
  input wire logic flag_f_val,
  output logic carry_flag,
  // Status word access
  input wire logic sw_wr_en,
  input wire logic [1:0] sw_wr_lanes,
  input wire logic [15:0] sw_wr_data,
  output logic [15:0] status_word,
  input wire logic priv_op_req,
  output logic privilege_fault,
  // Trace
  input wire logic instr_start,
  input wire logic instr_done,
  output logic trace_trap,
  // Interrupts and traps
  input wire logic irq_req,
  input wire logic nmi_req,
  output logic irq_accept,
  input wire logic irq_ack,
  input wire logic trap_entry,
  output logic [15:0] saved_status,
  input wire logic rti_en,
  input wire logic [15:0] rti_data,
  // Blit unit
  input wire logic blit_start,
  input wire logic blit_end,
  output logic blit_unit_select_n,
  // Setup register
  input wire logic setup_write_op,
  input wire logic [7:0] setup_wr_data,
  output logic vectored_mode,
  output logic [1:0] clock_scale_sel,
  // Floating point dispatch
  input wire logic float_op_req,
  output logic illegal_op_trap,
  output logic fpu_dispatch,
  // Memory beats on the 16-bit data path
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_data,
  output logic mem_beat_valid,
  output logic [23:0] mem_beat_addr,
  output logic [15:0] mem_beat_data,
  output logic [1:0] mem_beat_lanes,
  output logic mem_busy
);
  function automatic logic [31:0] merge_size(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [1:0] size);
    logic [31:0] res;
    res = new_val;
    case (size)
      crs_pkg::SIZE_BYTE: res = {old_val[31:8], new_val[7:0]};
      crs_pkg::SIZE_WORD: res = {old_val[31:16], new_val[15:0]};
      default: res = new_val;
    endcase
    return res;
  endfunction
  function automatic logic [23:0] size_bytes(input logic [1:0] size);
    logic [23:0] res;
    res = 24'h000004;
    case (size)
      crs_pkg::SIZE_BYTE: res = 24'h000001;
      crs_pkg::SIZE_WORD: res = 24'h000002;
      default: res = 24'h000004;
    endcase
    return res;
  endfunction
  function automatic logic [31:0] low_part(input logic [31:0] val, input logic [1:0] size);
    logic [31:0] res;
    res = val;
    case (size)
      crs_pkg::SIZE_BYTE: res = {24'h000000, val[7:0]};
      crs_pkg::SIZE_WORD: res = {16'h0000, val[15:0]};
      default: res = val;
    endcase
    return res;
  endfunction
  logic [31:0] gen_regs_ff [0:7];
  logic [23:0] pc_ff;
  logic [23:0] sp0_ff;
  logic [23:0] sp1_ff;
  logic [23:0] fp_ff;
  logic [23:0] sb_ff;
  logic [23:0] vt_ff;
  logic [15:0] mod_ff;
  logic [15:0] sw_ff;
  logic [15:0] nxt_sw;
  logic [7:0] setup_ff;
  logic user_mode;
  logic sp_pick;
  logic [23:0] sp_cur;
  logic [23:0] nxt_sp_cur;
  logic sw_hi_refused;
  logic setup_refused;
  crs_pkg::crs_beat_type beat_ff;
  logic [23:0] beat_addr_ff;
  logic [15:0] beat_hi_ff;
  assign user_mode = sw_ff[crs_pkg::SW_U];
  assign sp_pick = sw_ff[crs_pkg::SW_S];
  assign sp_cur = sp_pick ? sp1_ff : sp0_ff;
  assign sw_hi_refused = sw_wr_en && sw_wr_lanes[1] && user_mode;
  assign setup_refused = setup_write_op && user_mode;
  // Stack pointer after this cycle's push or pop
  always_comb begin
    nxt_sp_cur = sp_cur;
    if (stack_push) begin
      nxt_sp_cur = sp_cur - size_bytes(stack_size);
    end else if (stack_pop) begin
      nxt_sp_cur = sp_cur + size_bytes(stack_size);
    end
  end
  // General registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        gen_regs_ff[i] <= 32'h00000000;
      end
    end else if (gen_wr_en) begin
      gen_regs_ff[gen_wr_sel] <= merge_size(gen_regs_ff[gen_wr_sel], gen_wr_data,
                                            gen_wr_size);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      gen_rd_data <= 32'h00000000;
    end else begin
      gen_rd_data <= low_part(gen_regs_ff[gen_rd_sel], gen_rd_size);
    end
  end
  // Address registers; only 24 bits are stored, 16 for the module pointer
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pc_ff <= 24'h000000;
      fp_ff <= 24'h000000;
      sb_ff <= 24'h000000;
      vt_ff <= 24'h000000;
      mod_ff <= 16'h0000;
    end else if (addr_wr_en) begin
      case (addr_wr_sel)
        crs_pkg::AREG_PC: pc_ff <= addr_wr_data[23:0];
        crs_pkg::AREG_FP: fp_ff <= addr_wr_data[23:0];
        crs_pkg::AREG_SB: sb_ff <= addr_wr_data[23:0];
        crs_pkg::AREG_VT: vt_ff <= addr_wr_data[23:0];
        crs_pkg::AREG_MOD: mod_ff <= addr_wr_data[15:0];
        default: mod_ff <= mod_ff;
      endcase
    end
  end
  // Stack pointers; an explicit write wins over a push or pop
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sp0_ff <= 24'h000000;
      sp1_ff <= 24'h000000;
    end else begin
      if (addr_wr_en && (addr_wr_sel == crs_pkg::AREG_SP0 ||
          (addr_wr_sel == crs_pkg::AREG_SP_CUR && !sp_pick))) begin
        sp0_ff <= addr_wr_data[23:0];
      end else if (!sp_pick) begin
        sp0_ff <= nxt_sp_cur;
      end
      if (addr_wr_en && (addr_wr_sel == crs_pkg::AREG_SP1 ||
          (addr_wr_sel == crs_pkg::AREG_SP_CUR && sp_pick))) begin
        sp1_ff <= addr_wr_data[23:0];
      end else if (sp_pick) begin
        sp1_ff <= nxt_sp_cur;
      end
    end
  end
  // Access address: new pointer for a push, old pointer for a pop
  always_ff @(posedge clock) begin
    if (!resetn) begin
      stack_addr <= 32'h00000000;
    end else if (stack_push) begin
      stack_addr <= {8'h00, nxt_sp_cur};
    end else if (stack_pop) begin
      stack_addr <= {8'h00, sp_cur};
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      addr_rd_data <= 32'h00000000;
      descriptor_addr <= 32'h00000000;
    end else begin
      descriptor_addr <= {16'h0000, mod_ff};
      case (addr_rd_sel)
        crs_pkg::AREG_PC: addr_rd_data <= {8'h00, pc_ff};
        crs_pkg::AREG_SP_CUR: addr_rd_data <= {8'h00, sp_cur};
        crs_pkg::AREG_FP: addr_rd_data <= {8'h00, fp_ff};
        crs_pkg::AREG_SB: addr_rd_data <= {8'h00, sb_ff};
        crs_pkg::AREG_VT: addr_rd_data <= {8'h00, vt_ff};
        crs_pkg::AREG_MOD: addr_rd_data <= {16'h0000, mod_ff};
        crs_pkg::AREG_SP0: addr_rd_data <= {8'h00, sp0_ff};
        default: addr_rd_data <= {8'h00, sp1_ff};
      endcase
    end
  end
  // Status word next value, lowest priority first
  always_comb begin
    nxt_sw = sw_ff;
    if (cmp_en) begin
      nxt_sw[crs_pkg::SW_L] = cmp_float ? 1'b0 : (cmp_second < cmp_first);
      nxt_sw[crs_pkg::SW_Z] = (cmp_second == cmp_first);
      nxt_sw[crs_pkg::SW_N] = ($signed(cmp_second) < $signed(cmp_first));
    end
    if (arith_en) begin
      nxt_sw[crs_pkg::SW_C] = arith_carry;
      nxt_sw[crs_pkg::SW_F] = arith_overflow;
    end
    if (flag_f_wr) begin
      nxt_sw[crs_pkg::SW_F] = flag_f_val;
    end
    if (instr_start) begin
      nxt_sw[crs_pkg::SW_P] = sw_ff[crs_pkg::SW_T];
    end else if (instr_done && sw_ff[crs_pkg::SW_P]) begin
      nxt_sw[crs_pkg::SW_P] = 1'b0;
    end
    if (blit_start) begin
      nxt_sw[crs_pkg::SW_B] = 1'b1;
    end else if (blit_end) begin
      nxt_sw[crs_pkg::SW_B] = 1'b0;
    end
    if (sw_wr_en && sw_wr_lanes[0]) begin
      nxt_sw[7:0] = sw_wr_data[7:0];
    end
    if (sw_wr_en && sw_wr_lanes[1] && !user_mode) begin
      nxt_sw[15:8] = sw_wr_data[15:8];
    end
    if (rti_en) begin
      nxt_sw = rti_data;
    end
    if (trap_entry) begin
      nxt_sw[crs_pkg::SW_S] = 1'b0;
    end
    if (irq_ack) begin
      nxt_sw = sw_ff & ~crs_pkg::SW_ACK_CLEAR;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sw_ff <= crs_pkg::SW_RESET;
      status_word <= crs_pkg::SW_RESET;
      carry_flag <= 1'b0;
      blit_unit_select_n <= 1'b1;
    end else begin
      sw_ff <= nxt_sw;
      status_word <= nxt_sw;
      carry_flag <= nxt_sw[crs_pkg::SW_C];
      blit_unit_select_n <= ~nxt_sw[crs_pkg::SW_B];
    end
  end
  // Copy of the word as it stood when the interrupt was taken
  always_ff @(posedge clock) begin
    if (!resetn) begin
      saved_status <= 16'h0000;
    end else if (irq_ack || trap_entry) begin
      saved_status <= sw_ff;
    end
  end
  // Privilege, trace, interrupt acceptance pulses
  always_ff @(posedge clock) begin
    if (!resetn) begin
      privilege_fault <= 1'b0;
      trace_trap <= 1'b0;
      irq_accept <= 1'b0;
    end else begin
      privilege_fault <= (priv_op_req || sw_hi_refused || setup_refused) && user_mode;
      trace_trap <= instr_done && sw_ff[crs_pkg::SW_P];
      irq_accept <= nmi_req || (irq_req && sw_ff[crs_pkg::SW_I]);
    end
  end
  // Setup register
  always_ff @(posedge clock) begin
    if (!resetn) begin
      setup_ff <= crs_pkg::SU_RESET;
    end else if (setup_write_op && !user_mode) begin
      setup_ff <= setup_wr_data & crs_pkg::SU_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      vectored_mode <= 1'b0;
      clock_scale_sel <= 2'h0;
      illegal_op_trap <= 1'b0;
      fpu_dispatch <= 1'b0;
    end else begin
      vectored_mode <= setup_ff[crs_pkg::SU_VEC];
      clock_scale_sel <= {setup_ff[crs_pkg::SU_C], setup_ff[crs_pkg::SU_M]};
      illegal_op_trap <= float_op_req && !setup_ff[crs_pkg::SU_FPU];
      fpu_dispatch <= float_op_req && setup_ff[crs_pkg::SU_FPU];
    end
  end
  // Little-endian split of a request into 16-bit beats, low half first
  always_ff @(posedge clock) begin
    if (!resetn) begin
      beat_ff <= crs_pkg::CRS_BEAT_FIRST;
      beat_addr_ff <= 24'h000000;
      beat_hi_ff <= 16'h0000;
      mem_beat_valid <= 1'b0;
      mem_beat_addr <= 24'h000000;
      mem_beat_data <= 16'h0000;
      mem_beat_lanes <= 2'h0;
      mem_busy <= 1'b0;
    end else begin
      case (beat_ff)
        crs_pkg::CRS_BEAT_FIRST: begin
          mem_beat_valid <= mem_req;
          if (mem_req) begin
            mem_beat_addr <= mem_addr;
            mem_beat_data <= mem_data[15:0];
            mem_beat_lanes <= (mem_size == crs_pkg::SIZE_BYTE) ? 2'h1 : 2'h3;
            if (mem_size == crs_pkg::SIZE_DWORD) begin
              beat_ff <= crs_pkg::CRS_BEAT_SECOND;
              beat_addr_ff <= mem_addr + 24'h000002;
              beat_hi_ff <= mem_data[31:16];
              mem_busy <= 1'b1;
            end
          end
        end
        crs_pkg::CRS_BEAT_SECOND: begin
          mem_beat_valid <= 1'b1;
          mem_beat_addr <= beat_addr_ff;
          mem_beat_data <= beat_hi_ff;
          mem_beat_lanes <= 2'h3;
          mem_busy <= 1'b0;
          beat_ff <= crs_pkg::CRS_BEAT_FIRST;
        end
        default: beat_ff <= crs_pkg::CRS_BEAT_FIRST;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** crs_pkg.sv ***
`default_nettype none
package crs_pkg;
  // Operand sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;
  // Address register selectors
  localparam logic [2:0] AREG_PC = 3'h0;
  localparam logic [2:0] AREG_SP_CUR = 3'h1;
  localparam logic [2:0] AREG_FP = 3'h2;
  localparam logic [2:0] AREG_SB = 3'h3;
  localparam logic [2:0] AREG_VT = 3'h4;
  localparam logic [2:0] AREG_MOD = 3'h5;
  localparam logic [2:0] AREG_SP0 = 3'h6;
  localparam logic [2:0] AREG_SP1 = 3'h7;
  localparam int ADDR_BITS = 24;
  localparam int MOD_BITS = 16;
  // Status word fields
  localparam int SW_C = 0;
  localparam int SW_T = 1;
  localparam int SW_L = 2;
  localparam int SW_J = 3;
  localparam int SW_K = 4;
  localparam int SW_F = 5;
  localparam int SW_Z = 6;
  localparam int SW_N = 7;
  localparam int SW_U = 8;
  localparam int SW_S = 9;
  localparam int SW_P = 10;
  localparam int SW_I = 11;
  localparam int SW_B = 12;
  localparam logic [15:0] SW_RESET = 16'h0000;
  localparam logic [15:0] SW_ACK_CLEAR = 16'h1F00;
  // Setup register fields
  localparam int SU_VEC = 0;
  localparam int SU_FPU = 1;
  localparam int SU_M = 2;
  localparam int SU_C = 3;
  localparam logic [7:0] SU_MASK = 8'h0F;
  localparam logic [7:0] SU_RESET = 8'h00;
  typedef enum logic [0:0] {
    CRS_BEAT_FIRST = 1'b0,
    CRS_BEAT_SECOND = 1'b1
  } crs_beat_type;
endpackage
`default_nettype wire

// *** crs_register_set_chk.sv ***
`default_nettype none
module crs_register_set_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Status and privilege
  input wire logic [15:0] status_word,
  input wire logic carry_flag,
  input wire logic blit_unit_select_n,
  input wire logic sw_wr_en,
  input wire logic [1:0] sw_wr_lanes,
  input wire logic setup_write_op,
  input wire logic priv_op_req,
  input wire logic privilege_fault,
  input wire logic instr_done,
  input wire logic trace_trap,
  // Interrupts and traps
  input wire logic irq_req,
  input wire logic nmi_req,
  input wire logic irq_accept,
  input wire logic irq_ack,
  input wire logic trap_entry,
  // Float dispatch
  input wire logic float_op_req,
  input wire logic illegal_op_trap,
  input wire logic fpu_dispatch,
  // Address outputs
  input wire logic [31:0] addr_rd_data,
  input wire logic [31:0] descriptor_addr,
  // Memory beats
  input wire logic mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_data,
  input wire logic mem_beat_valid,
  input wire logic [23:0] mem_beat_addr,
  input wire logic [15:0] mem_beat_data,
  input wire logic mem_busy
);
  logic [23:0] req_addr_ff;
  logic [31:0] req_data_ff;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Remember the request that the memory path took
  always_ff @(posedge clock) begin
    if (mem_req && !mem_busy) begin
      req_addr_ff <= mem_addr;
      req_data_ff <= mem_data;
    end
  end
  sequence s_low_beat;
    mem_beat_valid && mem_busy && mem_beat_addr == req_addr_ff
      && mem_beat_data == req_data_ff[15:0];
  endsequence
  sequence s_high_beat;
    mem_beat_valid && !mem_busy && mem_beat_addr == req_addr_ff + 24'h2
      && mem_beat_data == req_data_ff[31:16];
  endsequence
  property p_dword_beats;
    mem_req && !mem_busy && mem_size == crs_pkg::SIZE_DWORD |=> s_low_beat ##1 s_high_beat;
  endproperty
  property p_blit_pin;
    blit_unit_select_n == !status_word[crs_pkg::SW_B];
  endproperty
  property p_carry_mirror;
    carry_flag == status_word[crs_pkg::SW_C];
  endproperty
  property p_ack_clear;
    irq_ack |=> status_word[12:8] == 5'h00 && blit_unit_select_n;
  endproperty
  property p_trap_pick;
    trap_entry && !irq_ack |=> !status_word[crs_pkg::SW_S];
  endproperty
  property p_irq_accept;
    $past(resetn) |-> irq_accept == ($past(nmi_req)
      || ($past(irq_req) && $past(status_word[crs_pkg::SW_I])));
  endproperty
  property p_trace_once;
    $past(resetn) |-> trace_trap == ($past(instr_done) && $past(status_word[crs_pkg::SW_P]));
  endproperty
  property p_float_one;
    float_op_req |=> illegal_op_trap != fpu_dispatch;
  endproperty
  property p_float_idle;
    !float_op_req |=> !illegal_op_trap && !fpu_dispatch;
  endproperty
  property p_user_fault;
    status_word[crs_pkg::SW_U] && (priv_op_req || setup_write_op || sw_wr_en && sw_wr_lanes[1])
      |=> privilege_fault;
  endproperty
  property p_super_quiet;
    !status_word[crs_pkg::SW_U] |=> !privilege_fault;
  endproperty
  property p_addr_upper;
    addr_rd_data[31:24] == 8'h00 && descriptor_addr[31:16] == 16'h0000;
  endproperty
  a_dword_beats: assert property (p_dword_beats) else $error("dword beats wrong");
  a_blit_pin: assert property (p_blit_pin) else $error("blit select mismatch");
  a_carry_mirror: assert property (p_carry_mirror) else $error("carry flag mismatch");
  a_ack_clear: assert property (p_ack_clear) else $error("ack clear wrong");
  a_trap_pick: assert property (p_trap_pick) else $error("trap kept pick bit");
  a_irq_accept: assert property (p_irq_accept) else $error("accept wrong");
  a_trace_once: assert property (p_trace_once) else $error("trace trap wrong");
  a_float_one: assert property (p_float_one) else $error("float result wrong");
  a_float_idle: assert property (p_float_idle) else $error("float pulse stray");
  a_user_fault: assert property (p_user_fault) else $error("user op not refused");
  a_super_quiet: assert property (p_super_quiet) else $error("stray fault");
  a_addr_upper: assert property (p_addr_upper) else $error("upper bits set");
endmodule
bind crs_register_set crs_register_set_chk crs_register_set_chk_inst (.*);
`default_nettype wire

// *** tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0, resetn = 1'h0;
  logic [2:0] gen_rd_sel = 3'h0, gen_wr_sel = 3'h0, addr_rd_sel = 3'h0, addr_wr_sel = 3'h0;
  logic [1:0] gen_rd_size = 2'h2, gen_wr_size = 2'h0, stack_size = 2'h0, sw_wr_lanes = 2'h0;
  logic [1:0] mem_size = 2'h0;
  logic gen_wr_en = 1'h0, addr_wr_en = 1'h0, stack_push = 1'h0, stack_pop = 1'h0;
  logic cmp_en = 1'h0, cmp_float = 1'h0, arith_en = 1'h0, arith_carry = 1'h0;
  logic arith_overflow = 1'h0, flag_f_wr = 1'h0, flag_f_val = 1'h0, sw_wr_en = 1'h0;
  logic priv_op_req = 1'h0, instr_start = 1'h0, instr_done = 1'h0, irq_req = 1'h0;
  logic nmi_req = 1'h0, irq_ack = 1'h0, trap_entry = 1'h0, rti_en = 1'h0, blit_start = 1'h0;
  logic blit_end = 1'h0, setup_write_op = 1'h0, float_op_req = 1'h0, mem_req = 1'h0;
  logic [31:0] gen_wr_data = 32'h0, addr_wr_data = 32'h0, cmp_first = 32'h0;
  logic [31:0] cmp_second = 32'h0, mem_data = 32'h0;
  logic [15:0] sw_wr_data = 16'h0, rti_data = 16'h0;
  logic [7:0] setup_wr_data = 8'h0;
  logic [23:0] mem_addr = 24'h0;
  logic [31:0] gen_rd_data, addr_rd_data, descriptor_addr, stack_addr;
  logic [15:0] status_word, saved_status, mem_beat_data;
  logic [23:0] mem_beat_addr;
  logic [1:0] clock_scale_sel, mem_beat_lanes;
  logic carry_flag, privilege_fault, trace_trap, irq_accept, blit_unit_select_n, vectored_mode;
  logic illegal_op_trap, fpu_dispatch, mem_beat_valid, mem_busy;
  int errors = 0, compares = 0;
  // Compare operands and expected {N,Z,L}
  logic [31:0] cf[3] = '{32'h3, 32'h1, 32'h5};
  logic [31:0] cs[3] = '{32'h3, 32'hFFFFFFFF, 32'h3};
  logic [2:0] ce[3] = '{3'h2, 3'h4, 3'h5};
  crs_register_set crs_register_set_inst (.*);
  always #2 clock = ~clock;
  task automatic tick(input int n = 1);
    repeat (n) @(negedge clock);
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick();
    s = 1'h0;
  endtask
  task automatic gen_wr(input logic [2:0] sel, input logic [1:0] size, input logic [31:0] d);
    gen_wr_sel = sel;
    gen_wr_size = size;
    gen_wr_data = d;
    pulse(gen_wr_en);
    tick();
  endtask
  task automatic gen_rd(input logic [2:0] sel, input logic [31:0] exp);
    gen_rd_sel = sel;
    tick(2);
    check("gen_rd_data", exp, gen_rd_data);
  endtask
  task automatic addr_wr(input logic [2:0] sel, input logic [31:0] d);
    addr_wr_sel = sel;
    addr_wr_data = d;
    pulse(addr_wr_en);
    tick();
  endtask
  task automatic addr_rd(input logic [2:0] sel, input logic [31:0] exp);
    addr_rd_sel = sel;
    tick(2);
    check("addr_rd_data", exp, addr_rd_data);
  endtask
  task automatic sw_wr(input logic [1:0] lanes, input logic [15:0] d);
    sw_wr_lanes = lanes;
    sw_wr_data = d;
    pulse(sw_wr_en);
  endtask
  task automatic complete_run;
    $display("Compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2000;
    errors++;
    complete_run();
  end
  initial begin
    tick(6);
    resetn = 1'h1;
    check("blit_sel", 32'h1, 32'(blit_unit_select_n));
    gen_wr(3'h2, 2'h2, 32'hAABBCCDD);
    gen_wr(3'h2, 2'h0, 32'h000000FF);
    gen_rd(3'h2, 32'hAABBCCFF);
    gen_wr(3'h2, 2'h1, 32'h55551234);
    gen_rd(3'h2, 32'hAABB1234);
    gen_rd_size = 2'h0;
    gen_rd(3'h2, 32'h00000034);
    gen_rd_size = 2'h2;
    addr_wr(3'h2, 32'hFFFFFFFF);
    addr_rd(3'h2, 32'h00FFFFFF);
    addr_wr(3'h5, 32'hFFFFFFFF);
    addr_rd(3'h5, 32'h0000FFFF);
    check("descriptor", 32'h0000FFFF, descriptor_addr);
    addr_wr(3'h6, 32'h00000100);
    stack_size = 2'h2;
    pulse(stack_push);
    check("push_addr", 32'h000000FC, stack_addr);
    addr_rd(3'h1, 32'h000000FC);
    sw_wr(2'h2, 16'hE200);
    check("status", 32'h0000E200, 32'(status_word));
    addr_wr(3'h7, 32'h00000200);
    stack_size = 2'h1;
    pulse(stack_push);
    check("push_addr", 32'h000001FE, stack_addr);
    stack_size = 2'h0;
    pulse(stack_pop);
    check("pop_addr", 32'h000001FE, stack_addr);
    addr_rd(3'h1, 32'h000001FF);
    addr_rd(3'h6, 32'h000000FC);
    pulse(trap_entry);
    check("status", 32'h0000E000, 32'(status_word));
    for (int i = 0; i < 3; i++) begin
      cmp_first = cf[i];
      cmp_second = cs[i];
      pulse(cmp_en);
      check("nzl", 32'(ce[i]), 32'({status_word[7:6], status_word[2]}));
      tick();
    end
    cmp_float = 1'h1;
    pulse(cmp_en);
    check("lower", 32'h0, 32'(status_word[2]));
    arith_carry = 1'h1;
    arith_overflow = 1'h1;
    pulse(arith_en);
    check("carry", 32'h1, 32'(carry_flag));
    check("cond", 32'h1, 32'(status_word[5]));
    pulse(flag_f_wr);
    check("cond", 32'h0, 32'(status_word[5]));
    sw_wr(2'h1, 16'h0002);
    pulse(instr_start);
    pulse(instr_done);
    check("trace", 32'h1, 32'(trace_trap));
    tick();
    pulse(instr_done);
    check("trace", 32'h0, 32'(trace_trap));
    sw_wr(2'h1, 16'h0000);
    irq_req = 1'h1;
    tick(2);
    check("accept", 32'h0, 32'(irq_accept));
    nmi_req = 1'h1;
    tick();
    check("accept", 32'h1, 32'(irq_accept));
    nmi_req = 1'h0;
    sw_wr(2'h2, 16'h0800);
    tick();
    check("accept", 32'h1, 32'(irq_accept));
    irq_req = 1'h0;
    sw_wr(2'h2, 16'h0E00);
    pulse(blit_start);
    check("blit_sel", 32'h0, 32'(blit_unit_select_n));
    pulse(irq_ack);
    check("saved", 32'h00001E00, 32'(saved_status));
    check("status", 32'h0, 32'(status_word));
    check("blit_sel", 32'h1, 32'(blit_unit_select_n));
    rti_data = 16'h1E00;
    pulse(rti_en);
    check("status", 32'h00001E00, 32'(status_word));
    pulse(blit_end);
    check("blit_sel", 32'h1, 32'(blit_unit_select_n));
    pulse(float_op_req);
    check("illegal", 32'h1, 32'(illegal_op_trap));
    setup_wr_data = 8'hFA;
    pulse(setup_write_op);
    tick();
    check("vectored", 32'h0, 32'(vectored_mode));
    check("scale", 32'h2, 32'(clock_scale_sel));
    pulse(float_op_req);
    check("dispatch", 32'h1, 32'(fpu_dispatch));
    setup_wr_data = 8'h05;
    pulse(setup_write_op);
    tick();
    check("vectored", 32'h1, 32'(vectored_mode));
    check("scale", 32'h1, 32'(clock_scale_sel));
    pulse(float_op_req);
    check("illegal", 32'h1, 32'(illegal_op_trap));
    sw_wr(2'h2, 16'h0100);
    tick();
    sw_wr(2'h3, 16'h0E50);
    check("fault", 32'h1, 32'(privilege_fault));
    check("status", 32'h00000150, 32'(status_word));
    pulse(priv_op_req);
    check("fault", 32'h1, 32'(privilege_fault));
    setup_wr_data = 8'h0A;
    pulse(setup_write_op);
    tick();
    check("vectored", 32'h1, 32'(vectored_mode));
    pulse(irq_ack);
    check("status", 32'h00000050, 32'(status_word));
    pulse(priv_op_req);
    check("fault", 32'h0, 32'(privilege_fault));
    mem_addr = 24'h000003;
    mem_data = 32'h11223344;
    mem_size = crs_pkg::SIZE_DWORD;
    pulse(mem_req);
    check("beat_addr", 32'h3, 32'(mem_beat_addr));
    check("beat_data", 32'h3344, 32'(mem_beat_data));
    check("beat_lanes", 32'h3, 32'(mem_beat_lanes));
    check("beat_busy", 32'h1, 32'(mem_busy));
    tick();
    check("beat_addr", 32'h5, 32'(mem_beat_addr));
    check("beat_data", 32'h1122, 32'(mem_beat_data));
    check("beat_lanes", 32'h3, 32'(mem_beat_lanes));
    check("beat_busy", 32'h0, 32'(mem_busy));
    mem_size = crs_pkg::SIZE_BYTE;
    pulse(mem_req);
    check("beat_lanes", 32'h1, 32'(mem_beat_lanes));
    check("beat_valid", 32'h1, 32'(mem_beat_valid));
    tick();
    check("beat_valid", 32'h0, 32'(mem_beat_valid));
    pulse(blit_start);
    check("blit_sel", 32'h0, 32'(blit_unit_select_n));
    resetn = 1'h0;
    tick();
    resetn = 1'h1;
    check("blit_sel", 32'h1, 32'(blit_unit_select_n));
    check("status", 32'h0, 32'(status_word));
    complete_run();
  end
endmodule
`default_nettype wire
